// ---- rtl/rpps_map.vh ----
// register offsets, field positions, reset values and codes for the pin select block
`ifndef RPPS_MAP_VH
`define RPPS_MAP_VH

`define RPPS_NUM_PINS 26
`define RPPS_SEL_W 5
`define RPPS_ADDR_W 12
`define RPPS_DATA_W 16

// register byte addresses
`define RPPS_OFF_SPI1_IN 12'h06A8
`define RPPS_OFF_OUT_16_17 12'h06D0
`define RPPS_OFF_OUT_18_19 12'h06D2
`define RPPS_OFF_LOCK 12'h0742
`define RPPS_OFF_KEY 12'h0744

// field positions
`define RPPS_HI_LSB 8
`define RPPS_LO_LSB 0

// reset values
`define RPPS_RST_SPI1_IN 16'h1F1F
`define RPPS_RST_OUT 16'h0000
`define RPPS_IMPL_MASK 16'h1F1F

// selection codes
`define RPPS_SEL_GROUND 5'h1F
`define RPPS_SEL_MAX_PIN 5'h19
`define RPPS_FN_PORT 5'h00

// unlock keys, written in order to the key register
`define RPPS_KEY1 16'h0046
`define RPPS_KEY2 16'h0057
`endif

// ---- rtl/rpps_in_mux.v ----
// one remappable input selector: pin index to peripheral input
`timescale 1ns/100ps
`include "rpps_map.vh"
module rpps_in_mux (
	// selection
	input wire [4:0] sel,
	// pads
	input wire [25:0] pins_in,
	// peripheral side
	output reg periph_in
);
	always @* begin
		// codes above the last pin and ground code both read low
		if (sel <= `RPPS_SEL_MAX_PIN) begin
			periph_in = pins_in[sel];
		end else begin
			periph_in = 1'b0;
		end
	end
endmodule

// ---- rtl/rpps_top.v ----
// peripheral pin select: input and output routing registers with write lock
// Behaviour
// - up to 26 remappable pins, index n
// - separate input and output routing registers
// - input and output routed independently
// - input routing per peripheral, 5-bit field
// - input field n connects pin n
// - lock blocks spurious routing changes
// - spi1 clock 12:8, data 4:0, reset ones
// - 11111 ground; 0..25 select pins
// - pin17 12:8, pin16 4:0, reset zero
// - pin19 12:8, pin18 4:0, reset zero
// - pins 16-19 outputs only large variant
`timescale 1ns/100ps
`include "rpps_map.vh"
module rpps_top #(
	parameter LARGE_VARIANT = 1,
	parameter NUM_FUNCS = 32
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	// register port
	input wire [11:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_q,
	// pads
	input wire [25:0] pins_in,
	input wire [25:0] port_out,
	input wire [25:0] port_oe,
	output wire [25:0] pins_out,
	output wire [25:0] pins_oe,
	// peripherals
	input wire [NUM_FUNCS-1:0] func_out,
	input wire [NUM_FUNCS-1:0] func_oe,
	output wire spi1_clock_in,
	output wire spi1_data_in,
	// status
	output wire route_locked
);
	////////////////////////////////////////////////////////////////////////
	reg [4:0] spi1_clock_in_select_q;
	reg [4:0] spi1_data_in_select_q;
	reg [4:0] pin16_function_select_q;
	reg [4:0] pin17_function_select_q;
	reg [4:0] pin18_function_select_q;
	reg [4:0] pin19_function_select_q;
	reg lock_q;
	reg key_stage_q;
	wire wr_ok;
	wire out_ok;

	// writes to routing only while unlocked; unlock needs two-key sequence
	assign wr_ok = reg_wr & ~lock_q;
	assign out_ok = (LARGE_VARIANT != 0);
	assign route_locked = lock_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			spi1_clock_in_select_q <= 5'h1F;
			spi1_data_in_select_q <= 5'h1F;
			pin16_function_select_q <= 5'h00;
			pin17_function_select_q <= 5'h00;
			pin18_function_select_q <= 5'h00;
			pin19_function_select_q <= 5'h00;
		end else if (wr_ok) begin
			// only the 5-bit fields store; other bits dropped
			case (reg_addr)
				`RPPS_OFF_SPI1_IN: begin
					spi1_clock_in_select_q <= reg_wdata[12:8];
					spi1_data_in_select_q <= reg_wdata[4:0];
				end
				`RPPS_OFF_OUT_16_17: begin
					if (out_ok) begin
						pin17_function_select_q <= reg_wdata[12:8];
						pin16_function_select_q <= reg_wdata[4:0];
					end
				end
				`RPPS_OFF_OUT_18_19: begin
					if (out_ok) begin
						pin19_function_select_q <= reg_wdata[12:8];
						pin18_function_select_q <= reg_wdata[4:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lock: write key1 then key2 to the key register to clear the lock; a lock register
	// write with bit 0 set locks at any time; any other write re-arms
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_q <= 1'b0;
			key_stage_q <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == `RPPS_OFF_KEY && reg_wdata == `RPPS_KEY1) begin
				key_stage_q <= 1'b1;
			end else if (reg_addr == `RPPS_OFF_KEY && reg_wdata == `RPPS_KEY2 && key_stage_q) begin
				key_stage_q <= 1'b0;
				lock_q <= 1'b0;
			end else if (reg_addr == `RPPS_OFF_LOCK) begin
				key_stage_q <= 1'b0;
				// setting the lock needs no key; clearing does
				if (reg_wdata[0]) begin
					lock_q <= 1'b1;
				end
			end else begin
				key_stage_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: data in the cycle after the strobe, zero otherwise
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`RPPS_OFF_SPI1_IN: begin
					reg_rdata_q <= {3'b000, spi1_clock_in_select_q, 3'b000,
						spi1_data_in_select_q};
				end
				`RPPS_OFF_OUT_16_17: begin
					reg_rdata_q <= out_ok ? {3'b000, pin17_function_select_q, 3'b000,
						pin16_function_select_q} : 16'h0000;
				end
				`RPPS_OFF_OUT_18_19: begin
					reg_rdata_q <= out_ok ? {3'b000, pin19_function_select_q, 3'b000,
						pin18_function_select_q} : 16'h0000;
				end
				`RPPS_OFF_LOCK: begin
					reg_rdata_q <= {15'h0000, lock_q};
				end
				default: begin
					reg_rdata_q <= 16'h0000;
				end
			endcase
		end else begin
			reg_rdata_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input routing; out-of-range codes fall to ground rather than aliasing
	rpps_in_mux u_sck_mux (
		.sel(spi1_clock_in_select_q),
		.pins_in(pins_in),
		.periph_in(spi1_clock_in)
	);
	rpps_in_mux u_sdi_mux (
		.sel(spi1_data_in_select_q),
		.pins_in(pins_in),
		.periph_in(spi1_data_in)
	);

	////////////////////////////////////////////////////////////////////////
	// output routing: function 0 hands the pin back to the port
	function [1:0] rpps_fn_drive;
		input [4:0] fsel;
		input port_o;
		input port_e;
		input [NUM_FUNCS-1:0] fo;
		input [NUM_FUNCS-1:0] fe;
		begin
			if (fsel == `RPPS_FN_PORT) begin
				rpps_fn_drive = {port_e, port_o};
			end else begin
				rpps_fn_drive = {fe[fsel], fo[fsel]};
			end
		end
	endfunction

	wire [4:0] out_sel [0:25];
	genvar gi;
	generate
		for (gi = 0; gi < `RPPS_NUM_PINS; gi = gi + 1) begin : g_pin
			wire [1:0] drv;
			assign out_sel[gi] = !out_ok ? 5'h00 :
				(gi == 16) ? pin16_function_select_q :
				(gi == 17) ? pin17_function_select_q :
				(gi == 18) ? pin18_function_select_q :
				(gi == 19) ? pin19_function_select_q : 5'h00;
			assign drv = rpps_fn_drive(out_sel[gi], port_out[gi], port_oe[gi],
				func_out, func_oe);
			assign pins_out[gi] = drv[0];
			assign pins_oe[gi] = drv[1];
		end
	endgenerate
endmodule

// ---- sim/rpps_top_monitor.sv ----
// checker for the pin select block ports
`timescale 1ns/100ps
module rpps_top_monitor #(parameter NUM_FUNCS = 32) (
	input wire clk,
	input wire reset_n,
	input wire [11:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata_q,
	input wire [25:0] pins_in,
	input wire [25:0] port_out,
	input wire [25:0] port_oe,
	input wire [25:0] pins_out,
	input wire [25:0] pins_oe,
	input wire [NUM_FUNCS-1:0] func_out,
	input wire spi1_clock_in,
	input wire spi1_data_in,
	input wire route_locked
);
	// read-back shows the live field, so routing is judged in the answer cycle
	wire rs = reg_rd && reg_addr == 12'h06A8;
	wire ro = reg_rd && reg_addr == 12'h06D0;
	wire [4:0] hi = reg_rdata_q[12:8];
	wire [4:0] lo = reg_rdata_q[4:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_idle; !$past(reg_rd) |-> reg_rdata_q == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("rdata off slot");
	property p_res; $past(reg_rd) |-> (reg_rdata_q & 16'hE0E0) == 16'h0000; endproperty
	a_res: assert property (p_res) else $error("unused bits set");
	property p_sck; $past(rs) && hi <= 5'h19 |-> spi1_clock_in == pins_in[hi]; endproperty
	a_sck: assert property (p_sck) else $error("clock route");
	property p_sdi; $past(rs) && lo <= 5'h19 |-> spi1_data_in == pins_in[lo]; endproperty
	a_sdi: assert property (p_sdi) else $error("data route");
	property p_gnd; $past(rs) && hi > 5'h19 |-> !spi1_clock_in; endproperty
	a_gnd: assert property (p_gnd) else $error("ground code");
	property p_fix; pins_out[15:0] == port_out[15:0] && pins_oe[25:20] == port_oe[25:20]; endproperty
	a_fix: assert property (p_fix) else $error("fixed pin");
	property p_p16; $past(ro) |-> pins_out[16] == (lo == 0 ? port_out[16] : func_out[lo]); endproperty
	a_p16: assert property (p_p16) else $error("pin16 route");
	property p_lock; $past(reg_wr && reg_addr == 12'h0742 && reg_wdata[0]) |-> route_locked; endproperty
	a_lock: assert property (p_lock) else $error("lock");
endmodule
bind rpps_top rpps_top_monitor #(.NUM_FUNCS(NUM_FUNCS)) rpps_top_monitor_inst (.*);

// ---- sim/rpps_far_model.sv ----
// far side: pads and peripherals as a shifting pattern, so every route sees moving levels
`timescale 1ns/100ps
module rpps_far_model (
	input wire clk,
	output wire [25:0] pins_in,
	output wire [25:0] port_out,
	output wire [25:0] port_oe,
	output wire [31:0] func_out,
	output wire [31:0] func_oe
);
	reg [31:0] s_q = 32'h0000_0001;
	always @(posedge clk) begin
		s_q <= {s_q[30:0], s_q[31] ^ s_q[21] ^ s_q[1] ^ s_q[0]};
	end
	assign pins_in = s_q[25:0];
	assign port_out = s_q[31:6];
	assign port_oe = ~s_q[25:0];
	assign func_out = {s_q[15:0], s_q[31:16]};
	assign func_oe = ~s_q;
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the pin select block
`timescale 1ns/100ps
module tb;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg [11:0] reg_addr = 12'h000;
	reg [15:0] reg_wdata = 16'h0000;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [15:0] reg_rdata_q;
	wire [25:0] pins_in, port_out, port_oe, pins_out, pins_oe;
	wire [31:0] func_out, func_oe;
	wire spi1_clock_in, spi1_data_in, route_locked;
	integer n_errors = 0;
	integer cmp_count = 0;
	integer k;
	initial begin
		forever #2.5 clk = ~clk;
	end
	rpps_far_model rpps_far_model_inst (.*);
	rpps_top rpps_top_inst (.*);
	task chk(input [15:0] seen, input [15:0] exp, input string what);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input [11:0] a, input [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input [11:0] a, input [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata_q, e, "rdata");
	endtask
	task t_reset;
		rd(12'h06A8, 16'h1F1F);
		rd(12'h06D0, 16'h0000);
		rd(12'h06D2, 16'h0000);
		chk(spi1_clock_in, 0, "sck");
		$display("reset test done");
	endtask
	// loop codes kept within the pin range; the two fields move opposite ways
	task t_in;
		for (k = 0; k < 26; k = k + 1) begin
			wr(12'h06A8, {3'b000, k[4:0], 3'b000, 5'd25 - k[4:0]});
			chk(spi1_clock_in, pins_in[k], "sck");
			chk(spi1_data_in, pins_in[25 - k], "sdi");
		end
		wr(12'h06A8, 16'hFFE3);
		rd(12'h06A8, 16'h1F03);
		$display("input test done");
	endtask
	task t_out;
		for (k = 0; k < 32; k = k + 1) begin
			wr(12'h06D0, {3'b000, k[4:0], 3'b000, k[4:0]});
			wr(12'h06D2, {3'b000, k[4:0], 3'b000, k[4:0]});
			chk(pins_out[19:16], k == 0 ? port_out[19:16] : {4{func_out[k]}}, "out");
			chk(pins_oe[19:16], k == 0 ? port_oe[19:16] : {4{func_oe[k]}}, "oe");
			chk(pins_out[15:0], port_out[15:0], "fixed");
			chk(pins_oe[15:0], port_oe[15:0], "fixed oe");
			chk(pins_out[25:20], port_out[25:20], "upper");
			chk(pins_oe[25:20], port_oe[25:20], "upper oe");
		end
		// last loop pass left function 31 on every output field
		rd(12'h06D0, 16'h1F1F);
		rd(12'h06D2, 16'h1F1F);
		rd(12'h06A8, 16'h1F03);
		$display("output test done");
	endtask
	task t_lock;
		wr(12'h06A8, 16'h0102);
		wr(12'h0742, 16'h0001);
		chk(route_locked, 1, "lock");
		wr(12'h06A8, 16'h0304);
		rd(12'h06A8, 16'h0102);
		wr(12'h0744, 16'h0046);
		wr(12'h0744, 16'h0057);
		chk(route_locked, 0, "lock");
		wr(12'h06A8, 16'h0304);
		rd(12'h06A8, 16'h0304);
		rd(12'h0100, 16'h0000);
		$display("lock test done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		t_in;
		t_out;
		t_lock;
		final_report;
	end
	// whole run is a few hundred cycles; this cuts a hang short
	initial begin
		#20000;
		n_errors = n_errors + 1;
		final_report;
	end
endmodule
